/* File: include/ipc_pkg.sv */
/*
  Constants for the interrupt priority and status register block: register
  offsets, field positions, reset values and widths.
  Assumes a 16-bit register port and a single synchronous clock domain.
*/
`default_nettype none
package ipc_pkg;
  // ==========================================================
  // register offsets (word index on the plain register port)
  localparam logic [3:0] IPC_OFF_STATUS   = 4'h0;
  localparam logic [3:0] IPC_OFF_CORE     = 4'h1;
  localparam logic [3:0] IPC_OFF_CTRL1    = 4'h2;
  localparam logic [3:0] IPC_OFF_CTRL2    = 4'h3;
  localparam logic [3:0] IPC_OFF_FLAGS    = 4'h4;
  localparam logic [3:0] IPC_OFF_ENABLE   = 4'h5;
  localparam logic [3:0] IPC_OFF_PRIO0    = 4'h6;
  localparam logic [3:0] IPC_OFF_PRIO3    = 4'h9;
  localparam logic [3:0] IPC_OFF_VECTOR   = 4'hA;
  // ==========================================================
  // field positions
  localparam int IPC_LVL_LO        = 5;
  localparam int IPC_LVL_HI        = 7;
  localparam int IPC_LVL_MSB_BIT   = 3;
  localparam int IPC_NEST_BIT      = 15;
  localparam int IPC_ALT_BIT       = 15;
  localparam int IPC_INSTR_DISABLE_ACTIVE_BIT      = 14;
  localparam int IPC_VEC_LVL_LO    = 8;
  // ==========================================================
  // writable masks and reset values
  localparam logic [15:0] IPC_FLAG_MASK  = 16'hBF8F;
  localparam logic [15:0] IPC_CTRL1_MASK = 16'h801E;
  localparam logic [15:0] IPC_CTRL2_MASK = 16'h8007;
  localparam logic [15:0] IPC_PRIO_MASK  = 16'h7777;
  localparam logic [15:0] IPC_RESET_WORD = 16'h0000;
  localparam logic [3:0]  IPC_TRAP_LEVEL = 4'h8;
  localparam logic [2:0]  IPC_LVL_MAX    = 3'h7;
  localparam int IPC_NSRC     = 16;
  localparam int IPC_PRIO_W   = 3;
  localparam int IPC_NPRIO    = 4;
  localparam int IPC_VEC_W    = 7;
  localparam int IPC_ILR_W    = 4;
endpackage : ipc_pkg
`default_nettype wire

/* File: design/ipc_top.sv */
/*
  Interrupt priority and status register block: source flags, enables,
  priorities, CPU level, trap and control bits, and pending vector arbitration.
  Assumes a synchronous register port with single-cycle strobes, and that
  source and trap request inputs are synchronous one-cycle or level pulses.
*/
`default_nettype none
// What this block does
// - latch winning vector number into 7-bit field and its level into 4-bit field
// - source n uses flag bit n, enable bit n and priority field n
// - status word bits 7:5 hold CPU level, software writes change it
// - core control bit 3 is read-only level msb, set above level 7
// - level is msb and three bits; level 7 or higher masks all user sources
// - CPU level bits are read-only while nesting disable is set
// - nesting disable at primary control bit 15, resets 0, read/write
// - trap flags at primary control bits 4..1, hardware set, software writable
// - secondary control bit 15 selects alternate vector table
// - secondary control bit 14 reads instruction-disable status, read-only
// - secondary control bits 2..0 select falling edge when 1 for ext 2..0
// - flags reset 0, hardware sets, software may write to clear
// - upper flag byte: bits 15, 13, 12, 11, 10, 9, 8 implemented
// - lower flag byte: bits 7, 3, 2, 1, 0 implemented
// - unimplemented bits read zero and ignore writes
// - enabled requests merge into one request line to the CPU
// - equal priority prefers the lower vector number
// - each source has a 3-bit priority field
module ipc_top
  import ipc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] src_req,
  input  wire logic [3:0]  trap_req,
  input  wire logic        cpu_lvl_msb_in,
  input  wire logic        instr_disable_in,
  output logic             cpu_irq,
  output logic      [6:0]  pending_vector_number,
  output logic      [3:0]  pending_level,
  output logic             alt_table_select,
  output logic      [2:0]  ext_edge_falling,
  output logic      [3:0]  cpu_level
);
  // ==========================================================
  // registers
  logic [15:0] flag_q, flag_d;
  logic [15:0] en_q, en_d;
  logic [15:0] prio_q [IPC_NPRIO];
  logic [15:0] ctrl1_q, ctrl1_d;
  logic [15:0] ctrl2_q, ctrl2_d;
  logic [2:0]  lvl_q, lvl_d;
  logic        lvl_msb_q;
  logic        instr_disable_active_q;
  logic [15:0] rdata_q, rdata_d;
  logic        irq_q;
  logic [6:0]  vec_q;
  logic [3:0]  ilr_q;

  // ==========================================================
  // address decode
  wire wr_status = reg_wr && (reg_addr == IPC_OFF_STATUS);
  wire wr_ctrl1  = reg_wr && (reg_addr == IPC_OFF_CTRL1);
  wire wr_ctrl2  = reg_wr && (reg_addr == IPC_OFF_CTRL2);
  wire wr_flags  = reg_wr && (reg_addr == IPC_OFF_FLAGS);
  wire wr_enable = reg_wr && (reg_addr == IPC_OFF_ENABLE);
  wire wr_prio   = reg_wr && (reg_addr >= IPC_OFF_PRIO0) && (reg_addr <= IPC_OFF_PRIO3);
  wire [1:0] prio_idx = 2'(reg_addr - IPC_OFF_PRIO0);
  wire nest_dis  = ctrl1_q[IPC_NEST_BIT];

  assign flag_d = wr_flags ? ((reg_wdata & IPC_FLAG_MASK) | (src_req & IPC_FLAG_MASK))
                           : (flag_q | (src_req & IPC_FLAG_MASK));
  assign en_d = wr_enable ? (reg_wdata & IPC_FLAG_MASK) : en_q;
  // trap flags set by hardware, writable
  wire [15:0] trap_set = {11'h000, trap_req, 1'b0};
  assign ctrl1_d = wr_ctrl1 ? ((reg_wdata & IPC_CTRL1_MASK) | trap_set) : (ctrl1_q | trap_set);
  // alt table and edge bits writable
  assign ctrl2_d = wr_ctrl2 ? (reg_wdata & IPC_CTRL2_MASK) : ctrl2_q;
  // level bits frozen while nesting disabled
  assign lvl_d = (wr_status && !nest_dis) ? reg_wdata[IPC_LVL_HI:IPC_LVL_LO] : lvl_q;

  // ==========================================================
  // arbitration
  // full level is msb over the three bits
  wire [3:0] cur_lvl = {lvl_msb_q, lvl_q};

  function automatic logic [2:0] src_prio(input int n, input logic [15:0] p [IPC_NPRIO]);
    logic [15:0] w;
    w = p[n / IPC_NPRIO];
    src_prio = w[(n % IPC_NPRIO) * IPC_NPRIO +: IPC_PRIO_W];
  endfunction : src_prio

  logic [2:0] best_p;
  logic [6:0] best_v;
  logic       best_ok;
  always_comb begin
    best_p  = 3'h0;
    best_v  = 7'h00;
    best_ok = 1'b0;
    // descending scan so lower vector wins ties
    for (int n = IPC_NSRC - 1; n >= 0; n--) begin
      // flag, enable, priority above CPU level
      if (flag_q[n] && en_q[n] && ({1'b0, src_prio(n, prio_q)} > cur_lvl) &&
          (src_prio(n, prio_q) >= best_p)) begin
        best_p  = src_prio(n, prio_q);
        best_v  = 7'(n);
        best_ok = 1'b1;
      end
    end
  end

  // ==========================================================
  // read mux; unmapped and unimplemented bits read zero
  always_comb begin
    rdata_d = IPC_RESET_WORD;
    if (reg_addr == IPC_OFF_STATUS) begin
      rdata_d[IPC_LVL_HI:IPC_LVL_LO] = lvl_q;
    end else if (reg_addr == IPC_OFF_CORE) begin
      rdata_d[IPC_LVL_MSB_BIT] = lvl_msb_q;
    end else if (reg_addr == IPC_OFF_CTRL1) begin
      rdata_d = ctrl1_q;
    end else if (reg_addr == IPC_OFF_CTRL2) begin
      rdata_d = ctrl2_q;
      rdata_d[IPC_INSTR_DISABLE_ACTIVE_BIT] = instr_disable_active_q;
    end else if (reg_addr == IPC_OFF_FLAGS) begin
      rdata_d = flag_q;
    end else if (reg_addr == IPC_OFF_ENABLE) begin
      // enable bit n for source n
      rdata_d = en_q;
    end else if ((reg_addr >= IPC_OFF_PRIO0) && (reg_addr <= IPC_OFF_PRIO3)) begin
      rdata_d = prio_q[prio_idx];
    end else if (reg_addr == IPC_OFF_VECTOR) begin
      rdata_d = {4'h0, ilr_q, 1'b0, vec_q};
    end
  end

  // ==========================================================
  // state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_q    <= IPC_RESET_WORD;
      en_q      <= IPC_RESET_WORD;
      ctrl1_q   <= IPC_RESET_WORD;
      ctrl2_q   <= IPC_RESET_WORD;
      lvl_q     <= 3'h0;
      lvl_msb_q <= 1'b0;
      instr_disable_active_q    <= 1'b0;
      rdata_q   <= IPC_RESET_WORD;
    end else if (clk_en) begin
      flag_q    <= flag_d;
      en_q      <= en_d;
      ctrl1_q   <= ctrl1_d;
      ctrl2_q   <= ctrl2_d;
      lvl_q     <= lvl_d;
      lvl_msb_q <= cpu_lvl_msb_in;
      instr_disable_active_q    <= instr_disable_in;
      rdata_q   <= reg_rd ? rdata_d : IPC_RESET_WORD;
    end
  end

  // 3-bit priority fields, four per register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < IPC_NPRIO; i++) prio_q[i] <= IPC_RESET_WORD;
    end else if (clk_en && wr_prio) begin
      prio_q[prio_idx] <= reg_wdata & IPC_PRIO_MASK;
    end
  end

  // pending vector latched only in cycles with a winner; merged request registered every cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      vec_q <= 7'h00;
      ilr_q <= 4'h0;
    end else if (clk_en) begin
      irq_q <= best_ok;
      if (best_ok) begin
        vec_q <= best_v;
        ilr_q <= {1'b0, best_p};
      end
    end
  end

  assign reg_rdata             = rdata_q;
  assign cpu_irq               = irq_q;
  assign pending_vector_number = vec_q;
  assign pending_level         = ilr_q;
  assign alt_table_select      = ctrl2_q[IPC_ALT_BIT];
  assign ext_edge_falling      = ctrl2_q[2:0];
  assign cpu_level             = cur_lvl;

  // ==========================================================
  // checks
  // hardware set not lost under clear
  flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && src_req[0]) |=>
    flag_q[0])
    else $error("flag set lost");

  flag_hole_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |->
    ((flag_q & ~IPC_FLAG_MASK) == 16'h0000))
    else $error("unimplemented flag set");

  lvl_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && nest_dis && wr_status) |=>
    $stable(lvl_q))
    else $error("level changed while locked");

  lvl_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !nest_dis && wr_status) |=>
    (lvl_q == $past(reg_wdata[IPC_LVL_HI:IPC_LVL_LO])))
    else $error("level write lost");

  lvl_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && (cur_lvl >= {1'b0, IPC_LVL_MAX})) |=>
    !cpu_irq)
    else $error("irq at masked level");

  irq_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && best_ok) |=>
    (cpu_irq && pending_level > $past(cur_lvl)))
    else $error("bad irq level");

  trap_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && trap_req[3]) |=>
    ctrl1_q[4])
    else $error("trap flag lost");

  vec_track_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && best_ok) |=>
    (pending_vector_number == $past(best_v)))
    else $error("vector mismatch");

  // read data only after a read strobe
  rd_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !reg_rd) |=>
    (reg_rdata == 16'h0000))
    else $error("read data without strobe");

  // software clear lands when no source fires
  flag_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wr_flags && (src_req == 16'h0000)) |=>
    (flag_q == ($past(reg_wdata) & IPC_FLAG_MASK)))
    else $error("flag write lost");

  en_hole_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |->
    ((en_q & ~IPC_FLAG_MASK) == 16'h0000))
    else $error("unimplemented enable set");

  prio_hole_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |->
    (((prio_q[0] | prio_q[1] | prio_q[2] | prio_q[3]) & ~IPC_PRIO_MASK) == 16'h0000))
    else $error("unimplemented priority bit set");

  ctrl1_hole_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |->
    ((ctrl1_q & ~IPC_CTRL1_MASK) == 16'h0000))
    else $error("unimplemented primary bit set");

  ctrl2_hole_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |->
    ((ctrl2_q & ~IPC_CTRL2_MASK) == 16'h0000))
    else $error("unimplemented secondary bit set");

  nest_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wr_ctrl1) |=>
    (ctrl1_q[IPC_NEST_BIT] == $past(reg_wdata[IPC_NEST_BIT])))
    else $error("nesting disable write lost");

  trap_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wr_ctrl1 && (trap_req == 4'h0)) |=>
    (ctrl1_q[4:1] == $past(reg_wdata[4:1])))
    else $error("trap flag write lost");

  alt_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wr_ctrl2) |=>
    (alt_table_select == $past(reg_wdata[IPC_ALT_BIT])))
    else $error("table select write lost");

  edge_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wr_ctrl2) |=>
    (ext_edge_falling == $past(reg_wdata[2:0])))
    else $error("edge polarity write lost");

  instr_disable_active_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && reg_rd && (reg_addr == IPC_OFF_CTRL2)) |=>
    (reg_rdata[IPC_INSTR_DISABLE_ACTIVE_BIT] == $past(instr_disable_active_q)))
    else $error("disable status readback wrong");

  msb_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && reg_rd && (reg_addr == IPC_OFF_CORE)) |=>
    (reg_rdata == {12'h000, $past(lvl_msb_q), 3'h0}))
    else $error("core control readback wrong");

  // no enabled flag means no request
  irq_merge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && ((flag_q & en_q) == 16'h0000)) |=>
    !cpu_irq)
    else $error("request without enabled flag");

  zero_prio_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && best_ok) |=>
    (pending_level != 4'h0))
    else $error("zero priority forwarded");

  vec_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !best_ok) |=>
    ($stable(pending_vector_number) && $stable(pending_level)))
    else $error("vector moved without winner");

  tie_pick_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && best_ok && flag_q[0] && en_q[0] && (src_prio(0, prio_q) == best_p)) |=>
    (pending_vector_number == 7'h00))
    else $error("natural order not kept");

  // clock enable low freezes state
  freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clk_en |=>
    ($stable(flag_q) && $stable(en_q) && $stable(lvl_q) && $stable(ctrl1_q) && $stable(reg_rdata)))
    else $error("state moved while frozen");
endmodule : ipc_top
`default_nettype wire

/* File: bench/ipc_cpu_model.sv */
/*
  cpu core stand-in: supplies the level msb and the disable-instruction status,
  and takes the pending vector while the request line is high.
  assumes one clock and an active-low synchronous reset.
*/
`default_nettype none
module ipc_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       cpu_irq,
  input  wire logic [6:0] vec,
  input  wire logic       trap_cmd,
  input  wire logic       instr_disable_active_cmd,
  output logic            lvl_msb_q,
  output logic            instr_disable_active_q,
  output logic [6:0]      taken_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // core state
  // core drives msb and status
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lvl_msb_q <= 1'b0;
      instr_disable_active_q    <= 1'b0;
      taken_q   <= 7'h00;
    end else begin
      lvl_msb_q <= trap_cmd;
      instr_disable_active_q    <= instr_disable_active_cmd;
      if (cpu_irq) taken_q <= vec;
    end
  end
endmodule : ipc_cpu_model
`default_nettype wire

/* File: bench/ipc_top_test.sv */
/*
  self-checking bench for the interrupt priority and status block.
  assumes the register port answers one cycle after a read strobe.
*/
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module ipc_top_test;
  import ipc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_n, clk_en, reg_wr, reg_rd, cpu_irq, alt, msb, instr_disable_active, trap_cmd, instr_disable_active_cmd;
  logic [3:0]  reg_addr, trap_req, lvl, cpu_level;
  logic [15:0] reg_wdata, reg_rdata, src_req;
  logic [6:0]  vec, taken;
  logic [2:0]  edge_f;
  int failures, comparisons;
  ipc_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_req(src_req), .trap_req(trap_req), .cpu_lvl_msb_in(msb), .instr_disable_in(instr_disable_active),
    .cpu_irq(cpu_irq), .pending_vector_number(vec), .pending_level(lvl),
    .alt_table_select(alt), .ext_edge_falling(edge_f), .cpu_level(cpu_level));
  ipc_cpu_model cpu_u (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_irq(cpu_irq), .vec(vec),
    .trap_cmd(trap_cmd), .instr_disable_active_cmd(instr_disable_active_cmd), .lvl_msb_q(msb), .instr_disable_active_q(instr_disable_active), .taken_q(taken));
  // ==========================================================
  // bus tasks
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [3:0] al [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hA, 4'hF};
    foreach (al[i]) rd(al[i], 16'h0000);
  endtask : t_reset
  task automatic t_masks;
    wr(4'h4, 16'hFFFF); rd(4'h4, 16'hBF8F);
    wr(4'h4, 16'h0000); rd(4'h4, 16'h0000);
    wr(4'h5, 16'hFFFF); rd(4'h5, 16'hBF8F);
    wr(4'h7, 16'hFFFF); rd(4'h7, 16'h7777);
    wr(4'hA, 16'hFFFF); rd(4'hA, 16'h0000);
    wr(4'h5, 16'h0000); wr(4'h7, 16'h0000);
    wr(4'h2, 16'hFFFF); rd(4'h2, 16'h801E);
    wr(4'h3, 16'hFFFF); rd(4'h3, 16'h8007);
    `CHK({alt, edge_f}, 4'hF)
    wr(4'h3, 16'h0004); cyc(1); `CHK({alt, edge_f}, 4'h4)
    wr(4'h2, 16'h0000); wr(4'h3, 16'h0000);
  endtask : t_masks
  task automatic t_level;
    wr(4'h0, 16'hFFFF); rd(4'h0, 16'h00E0);
    `CHK(cpu_level, 4'h7)
    wr(4'h1, 16'hFFFF); rd(4'h1, 16'h0000);
    trap_cmd <= 1'b1; cyc(3);
    rd(4'h1, 16'h0008);
    `CHK(cpu_level, 4'hF)
    trap_cmd <= 1'b0;
    wr(4'h2, 16'h8000); wr(4'h0, 16'h0020); rd(4'h0, 16'h00E0);
    wr(4'h2, 16'h0000); wr(4'h0, 16'h0020); rd(4'h0, 16'h0020);
    wr(4'h0, 16'h0000);
  endtask : t_level
  task automatic t_arb;
    wr(4'h5, 16'h000A); wr(4'h6, 16'h5050);
    @(posedge sys_clk); src_req <= 16'h000A;
    @(posedge sys_clk); src_req <= 16'h0000;
    cyc(3);
    `CHK(cpu_irq, 1'b1)
    `CHK({vec, lvl}, {7'h01, 4'h5})
    `CHK(taken, 7'h01)
    rd(4'hA, 16'h0501);
    wr(4'h6, 16'h6050); cyc(2);
    `CHK({vec, lvl}, {7'h03, 4'h6})
    wr(4'h0, 16'h00E0); cyc(2);
    `CHK(cpu_irq, 1'b0)
    `CHK(vec, 7'h03)
    wr(4'h0, 16'h0000); wr(4'h6, 16'h0000); cyc(2);
    `CHK(cpu_irq, 1'b0)
    rd(4'h4, 16'h000A);
    wr(4'h4, 16'h0000); rd(4'h4, 16'h0000);
  endtask : t_arb
  task automatic t_trap;
    @(posedge sys_clk); trap_req <= 4'hF;
    @(posedge sys_clk); trap_req <= 4'h0;
    rd(4'h2, 16'h001E);
    wr(4'h2, 16'h0000); rd(4'h2, 16'h0000);
    instr_disable_active_cmd <= 1'b1; cyc(3); rd(4'h3, 16'h4000);
    instr_disable_active_cmd <= 1'b0; cyc(3); rd(4'h3, 16'h0000);
  endtask : t_trap
  task automatic t_freeze;
    @(posedge sys_clk); clk_en <= 1'b0; src_req <= 16'h0001;
    @(posedge sys_clk); src_req <= 16'h0000;
    @(posedge sys_clk); clk_en <= 1'b1;
    rd(4'h4, 16'h0000);
  endtask : t_freeze
  // ==========================================================
  // run control
  task automatic summarize;
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #20000;
    failures++;
    summarize();
  end
  initial begin
    rst_n = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
    src_req = 16'h0000; trap_req = 4'h0; trap_cmd = 1'b0; instr_disable_active_cmd = 1'b0;
    failures = 0; comparisons = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset(); t_masks(); t_level(); t_arb(); t_trap(); t_freeze();
    summarize();
  end
endmodule : ipc_top_test
`default_nettype wire
